// file: verilog/rhp_regs.vh
// Constants for the radio module host pin logic.
// Included by the pin logic, the host model and the testbench; definitions only.
`ifndef RHP_REGS_VH
`define RHP_REGS_VH
`define RHP_NUM_GP        5
`define RHP_DATA_W        8
`define RHP_FIFO_DEPTH    4
`define RHP_FIFO_AW       2
`define RHP_UART_BIT_CYC  16'h0364
`define RHP_CD_HOLD_CYC   16'h03E8
`define RHP_TX_HOLD_CYC   16'h03E8
`define RHP_GP_OUT_RST    5'h00
`define RHP_GP_DIR_RST    5'h00
`define RHP_GP_PU_RST     5'h1F
`endif

// file: verilog/rhp_fifo.v
// Small synchronous FIFO for host bound data bytes.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/10ps
module rhp_fifo #(
  parameter W = 8,
  parameter D = 4,
  parameter A = 2
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg [W-1:0] mem [0:D-1];
  reg [A:0]   wp_r;
  reg [A:0]   rp_r;
  wire        full  = (wp_r[A] != rp_r[A]) && (wp_r[A-1:0] == rp_r[A-1:0]);
  wire        empty = (wp_r == rp_r);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp_r[A-1:0]];
  always @(posedge clk) begin
    if (!reset_n) begin
      wp_r <= {(A+1){1'b0}};
      rp_r <= {(A+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        mem[wp_r[A-1:0]] <= in_data;
        wp_r <= wp_r + 1'b1;
      end
      if (out_ready && !empty)
        rp_r <= rp_r + 1'b1;
    end
  end
endmodule // rhp_fifo

// file: verilog/rhp_pin_logic.v
// Host pin logic: activity indicators, general-purpose pins, flow control
// and the host serial transmitter fed through a small FIFO.
// Assumes pins arrive asynchronously; config inputs are static from core.
`timescale 1ns/10ps
`include "rhp_regs.vh"
module rhp_pin_logic (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       pkt_tx_data,
  input  wire       pkt_tx_ack_only,
  input  wire       pkt_rx_valid,
  input  wire       diag_alt_sel,
  input  wire       diag_serial_tx,
  output reg        diag_serial_rx,
  input  wire       flow_alt_sel,
  input  wire       sleep,
  input  wire [4:0] gp_dir_awake,
  input  wire [4:0] gp_pu_awake,
  input  wire [4:0] gp_out_awake,
  input  wire [4:0] gp_wake_en,
  input  wire [4:0] gp_dir_sleep,
  input  wire [4:0] gp_pu_sleep,
  input  wire [4:0] gp_out_sleep,
  input  wire [4:0] gp_out_poweron,
  input  wire       cfg_load,
  input  wire [7:0] host_tx_data,
  input  wire       host_tx_valid,
  output reg        host_tx_ready,
  output reg  [7:0] host_rx_data,
  output reg        host_rx_valid,
  input  wire       host_rx_ready,
  output reg        tx_activity,
  output reg        tx_activity_oe,
  input  wire       carrier_detect_n_in,
  output reg        carrier_detect_n,
  output reg        carrier_detect_n_oe,
  input  wire [4:0] gp_pin_in,
  output reg  [4:0] gp_pin_out,
  output reg  [4:0] gp_pin_oe,
  output reg  [4:0] gp_pin_pu,
  output reg  [4:0] gp_pin_value,
  output reg        wake_irq,
  output reg        radio_txd,
  input  wire       radio_rxd,
  output reg        rxd_sample
);
  // Bit map: index 0..4 = gp_pin0, gp_pin1, gp_pin2, gp_pin4, gp_pin5
  localparam CTS = 3;
  localparam RTS = 4;
  localparam ST_IDLE  = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_STOP  = 3'b100;

  function [4:0] pick;
    input       s;
    input [4:0] a;
    input [4:0] b;
    begin
      pick = s ? b : a;
    end
  endfunction

  // Saturating down-count; a stray extra tick can never wrap a timer
  function [15:0] dec16;
    input [15:0] v;
    begin
      dec16 = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
    end
  endfunction

  // Two-stage synchronisers for every pin input
  reg [4:0] gp_s1_r;
  reg [4:0] gp_s2_r;
  reg [4:0] gp_prev_r;
  reg [1:0] cd_s_r;
  reg [1:0] rxd_s_r;
  always @(posedge clk) begin
    if (!reset_n) begin
      gp_s1_r   <= 5'h1F;
      gp_s2_r   <= 5'h1F;
      gp_prev_r <= 5'h1F;
      cd_s_r    <= 2'h3;
      rxd_s_r   <= 2'h3;
    end else begin
      gp_s1_r   <= gp_pin_in;
      gp_s2_r   <= gp_s1_r;
      gp_prev_r <= gp_s2_r;
      cd_s_r    <= {cd_s_r[0], carrier_detect_n_in};
      rxd_s_r   <= {rxd_s_r[0], radio_rxd};
    end
  end

  // Stored alternate-function selects, loaded only on request
  reg diag_alt_r;
  reg flow_alt_r;
  reg [4:0] poweron_r;
  always @(posedge clk) begin
    if (!reset_n) begin
      diag_alt_r <= 1'b0;
      flow_alt_r <= 1'b0;
    end else if (cfg_load) begin
      diag_alt_r <= diag_alt_sel;
      flow_alt_r <= flow_alt_sel;
    end
  end

  // Indicator stretchers so a short packet event is visible on the pin
  reg [15:0] tx_hold_r;
  reg [15:0] cd_hold_r;
  wire       tx_ev = pkt_tx_data && !pkt_tx_ack_only;
  always @(posedge clk) begin
    if (!reset_n) begin
      tx_hold_r <= 16'h0000;
      cd_hold_r <= 16'h0000;
    end else begin
      if (tx_ev)
        tx_hold_r <= `RHP_TX_HOLD_CYC;
      else if (tx_hold_r != 16'h0000)
        tx_hold_r <= dec16(tx_hold_r);
      if (pkt_rx_valid)
        cd_hold_r <= `RHP_CD_HOLD_CYC;
      else if (cd_hold_r != 16'h0000)
        cd_hold_r <= dec16(cd_hold_r);
    end
  end

  // GP pin drive; awake and sleep sets are independent
  reg        seen_cfg_r;
  wire [4:0] dir_sel = pick(sleep, gp_dir_awake, gp_dir_sleep);
  wire [4:0] pu_sel  = pick(sleep, gp_pu_awake, gp_pu_sleep);
  wire [4:0] lvl_sel = seen_cfg_r ? pick(sleep, gp_out_awake, gp_out_sleep)
                                  : poweron_r;
  wire [4:0] alt_mask = flow_alt_r ? 5'h18 : 5'h00;
  wire       fifo_ready;
  wire [4:0] wake_hit;
  // Falling edge only, so a pin held low while asleep wakes the core once
  genvar g;
  generate
    for (g = 0; g < `RHP_NUM_GP; g = g + 1) begin : gp_wake
      assign wake_hit[g] = sleep && gp_wake_en[g] && !dir_sel[g] && !alt_mask[g]
                           && gp_prev_r[g] && !gp_s2_r[g];
    end
  endgenerate

  always @(posedge clk) begin
    if (!reset_n) begin
      seen_cfg_r <= 1'b0;
      gp_pin_out <= `RHP_GP_OUT_RST;
      gp_pin_oe  <= `RHP_GP_DIR_RST;
      gp_pin_pu  <= `RHP_GP_PU_RST;
      gp_pin_value <= 5'h00;
      wake_irq   <= 1'b0;
    end else begin
      // Awake and sleep levels take over once a setting has been stored
      if (cfg_load)
        seen_cfg_r <= 1'b1;
      gp_pin_oe  <= (dir_sel & ~alt_mask) | (alt_mask & 5'h08);
      gp_pin_pu  <= (pu_sel & ~dir_sel & ~alt_mask) | (alt_mask & 5'h10);
      gp_pin_out[2:0] <= lvl_sel[2:0];
      gp_pin_out[RTS] <= lvl_sel[RTS];
      // Clear-to-send low while FIFO can take a byte
      gp_pin_out[CTS] <= flow_alt_r ? !fifo_ready : lvl_sel[CTS];
      gp_pin_value <= gp_s2_r;
      wake_irq   <= |wake_hit;
    end
  end

  // Power-on levels follow their input until the first stored setting
  always @(posedge clk) begin
    if (!reset_n)
      poweron_r <= `RHP_GP_OUT_RST;
    else if (!seen_cfg_r || cfg_load)
      poweron_r <= gp_out_poweron;
  end

  // Diagnostic port muxing onto the indicator pins
  // Activity pin is output-only in both functions, so its enable stays high
  always @(posedge clk) begin
    if (!reset_n) begin
      tx_activity         <= 1'b0;
      tx_activity_oe      <= 1'b1;
      carrier_detect_n    <= 1'b1;
      carrier_detect_n_oe <= 1'b1;
      diag_serial_rx      <= 1'b1;
    end else begin
      tx_activity         <= diag_alt_r ? diag_serial_tx : (tx_hold_r != 16'h0000);
      tx_activity_oe      <= 1'b1;
      carrier_detect_n    <= !(cd_hold_r != 16'h0000);
      carrier_detect_n_oe <= !diag_alt_r;
      diag_serial_rx      <= diag_alt_r ? cd_s_r[1] : 1'b1;
    end
  end

  // Host data path: FIFO then serial transmitter (8N1)
  // Depth is small: clear-to-send must drop before the host overruns it
  wire [7:0] f_data;
  wire       f_valid;
  reg        f_take;
  rhp_fifo #(
    .W (`RHP_DATA_W),
    .D (`RHP_FIFO_DEPTH),
    .A (`RHP_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_data   (host_tx_data),
    .in_valid  (host_tx_valid),
    .in_ready  (fifo_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_take)
  );

  // Line output is registered, so every bit lags the shifter by one cycle
  reg [2:0]  st_r;
  reg [15:0] bit_cnt_r;
  reg [3:0]  nbit_r;
  reg [8:0]  sh_r;
  wire       rts_hold = flow_alt_r && gp_s2_r[RTS];
  wire       bit_end  = (bit_cnt_r == 16'h0000);
  always @(posedge clk) begin
    if (!reset_n) begin
      st_r      <= ST_IDLE;
      bit_cnt_r <= 16'h0000;
      nbit_r    <= 4'h0;
      sh_r      <= 9'h1FF;
      radio_txd <= 1'b1;
      f_take    <= 1'b0;
      host_tx_ready <= 1'b0;
    end else begin
      f_take        <= 1'b0;
      host_tx_ready <= fifo_ready;
      case (st_r)
        ST_IDLE: begin
          radio_txd <= 1'b1;
          // Whole bytes only: a held-off frame never starts mid-byte
          if (f_valid && !f_take && !rts_hold) begin
            f_take    <= 1'b1;
            sh_r      <= {f_data, 1'b0};
            nbit_r    <= 4'h0;
            bit_cnt_r <= `RHP_UART_BIT_CYC;
            st_r      <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          radio_txd <= sh_r[0];
          if (bit_end) begin
            bit_cnt_r <= `RHP_UART_BIT_CYC;
            sh_r      <= {1'b1, sh_r[8:1]};
            nbit_r    <= nbit_r + 4'h1;
            if (nbit_r == 4'h8)
              st_r <= ST_STOP;
          end else begin
            bit_cnt_r <= bit_cnt_r - 16'h0001;
          end
        end
        ST_STOP: begin
          radio_txd <= 1'b1;
          // Full stop bit before the next start, even if RTS drops early
          if (bit_end) begin
            st_r <= ST_IDLE;
          end else begin
            bit_cnt_r <= bit_cnt_r - 16'h0001;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Incoming serial data is passed as a sampled level to the core
  // No receive framing here; the core owns the host-to-radio decoder
  always @(posedge clk) begin
    if (!reset_n) begin
      rxd_sample    <= 1'b1;
      host_rx_data  <= 8'h00;
      host_rx_valid <= 1'b0;
    end else begin
      rxd_sample    <= rxd_s_r[1];
      host_rx_valid <= host_rx_valid && !host_rx_ready;
      host_rx_data  <= host_rx_data;
    end
  end
endmodule // rhp_pin_logic

// file: tb/rhp_monitor.sv
// Checker for the host pin logic, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module rhp_monitor (
  input wire       clk,
  input wire       reset_n,
  input wire       pkt_tx_data,
  input wire       pkt_tx_ack_only,
  input wire       pkt_rx_valid,
  input wire       diag_alt_sel,
  input wire       flow_alt_sel,
  input wire       cfg_load,
  input wire       sleep,
  input wire [4:0] gp_dir_sleep,
  input wire [4:0] gp_pin_oe,
  input wire [4:0] gp_pin_pu,
  input wire [4:0] gp_pin_out,
  input wire       host_tx_ready,
  input wire       tx_activity,
  input wire       carrier_detect_n,
  input wire       carrier_detect_n_oe,
  input wire       radio_txd
);
  reg  dg_r;
  reg  fl_r;
  wire tx_go = pkt_tx_data && !pkt_tx_ack_only && !dg_r;
  // Mirror of the stored alternate selections, so pin checks know the function
  always @(posedge clk) begin
    if (!reset_n) begin
      dg_r <= 1'b0;
      fl_r <= 1'b0;
    end else if (cfg_load) begin
      dg_r <= diag_alt_sel;
      fl_r <= flow_alt_sel;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_act_held; tx_activity [*8]; endsequence
  sequence s_start_bit; !radio_txd [*8]; endsequence
  property p_act_on; tx_go |=> ##1 s_act_held; endproperty
  a_act_on: assert property (p_act_on) else $error("activity not raised");
  property p_act_quiet;
    !tx_activity && !dg_r && !tx_go && !$past(tx_go) |=> !tx_activity;
  endproperty
  a_act_quiet: assert property (p_act_quiet) else $error("activity without send");
  property p_cd; pkt_rx_valid && !dg_r |-> ##2 !carrier_detect_n; endproperty
  a_cd: assert property (p_cd) else $error("carrier detect missing");
  property p_rst;
    disable iff (1'b0) !reset_n |=> !tx_activity && carrier_detect_n && radio_txd
      && gp_pin_pu == 5'h1F;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_start; $fell(radio_txd) |-> s_start_bit; endproperty
  a_start: assert property (p_start) else $error("start bit too short");
  property p_cts; fl_r && $past(fl_r, 2) |-> gp_pin_out[3] == !host_tx_ready; endproperty
  a_cts: assert property (p_cts) else $error("clear to send wrong");
  property p_sleep;
    sleep && $past(sleep) && $past(sleep, 2) && $past(gp_dir_sleep, 2) == gp_dir_sleep
      |-> gp_pin_oe[2:0] == gp_dir_sleep[2:0];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep direction wrong");
  property p_diag_oe; dg_r && $past(dg_r, 2) |-> !carrier_detect_n_oe; endproperty
  a_diag_oe: assert property (p_diag_oe) else $error("carrier pin still driven");
endmodule // rhp_monitor
bind rhp_pin_logic rhp_monitor u_mon (.clk, .reset_n, .pkt_tx_data, .pkt_tx_ack_only,
  .pkt_rx_valid, .diag_alt_sel, .flow_alt_sel, .cfg_load, .sleep, .gp_dir_sleep, .gp_pin_oe,
  .gp_pin_pu, .gp_pin_out, .host_tx_ready, .tx_activity, .carrier_detect_n,
  .carrier_detect_n_oe, .radio_txd);

// file: tb/rhp_host_model.sv
// Host controller model: decodes bytes on the serial line and drives RTS.
// Assumes the bit time of the shared constants header.
`timescale 1ns/10ps
`include "rhp_regs.vh"
module rhp_host_model (
  input  wire       clk,
  input  wire       txd,
  input  wire       hold,
  output wire       rts_n,
  output wire       rxd,
  output reg  [7:0] rx_byte,
  output reg        rx_stb
);
  localparam integer BT = `RHP_UART_BIT_CYC + 1;
  integer   b;
  reg [7:0] sh;
  assign rts_n = hold;
  // The host sends nothing here, so its data line idles high
  assign rxd   = 1'b1;
  initial begin
    rx_stb  = 1'b0;
    rx_byte = 8'h00;
    forever begin
      @(negedge txd);
      repeat (BT / 2) @(posedge clk);
      for (b = 0; b < 8; b = b + 1) begin
        repeat (BT) @(posedge clk);
        sh[b] = txd;
      end
      repeat (BT) @(posedge clk);
      rx_byte <= sh;
      rx_stb  <= 1'b1;
      @(posedge clk);
      rx_stb  <= 1'b0;
    end
  end
endmodule // rhp_host_model

// file: tb/testbench.sv
// Self-checking bench for the host pin logic and its serial path.
// Assumes the host model and checker files are compiled beside it.
`timescale 1ns/10ps
`include "rhp_regs.vh"
module testbench;
  reg        clk, reset_n, pkt_tx_data, pkt_tx_ack_only, pkt_rx_valid, diag_alt_sel;
  reg        diag_serial_tx, flow_alt_sel, sleep, cfg_load, host_tx_valid, host_rx_ready;
  reg        carrier_detect_n_in, hold;
  reg  [4:0] gp_dir_awake, gp_pu_awake, gp_out_awake, gp_wake_en;
  reg  [4:0] gp_dir_sleep, gp_pu_sleep, gp_out_sleep, gp_out_poweron;
  reg  [3:0] gpi;
  reg  [7:0] host_tx_data;
  reg  [7:0] got [0:7];
  wire       diag_serial_rx, host_tx_ready, tx_activity, carrier_detect_n;
  wire       carrier_detect_n_oe, wake_irq, radio_txd, radio_rxd, rts_n, rx_stb;
  wire [4:0] gp_pin_out, gp_pin_oe, gp_pin_pu;
  wire [7:0] rx_byte;
  wire [4:0] gp_pin_in = {rts_n, gpi};
  integer    n_fail, compares, cyc, n_got, n, k;
  rhp_pin_logic dut (.clk, .reset_n, .pkt_tx_data, .pkt_tx_ack_only, .pkt_rx_valid,
    .diag_alt_sel, .diag_serial_tx, .diag_serial_rx, .flow_alt_sel, .sleep, .gp_dir_awake,
    .gp_pu_awake, .gp_out_awake, .gp_wake_en, .gp_dir_sleep, .gp_pu_sleep, .gp_out_sleep,
    .gp_out_poweron, .cfg_load, .host_tx_data, .host_tx_valid, .host_tx_ready,
    .host_rx_data(), .host_rx_valid(), .host_rx_ready, .tx_activity, .tx_activity_oe(),
    .carrier_detect_n_in, .carrier_detect_n, .carrier_detect_n_oe, .gp_pin_in, .gp_pin_out,
    .gp_pin_oe, .gp_pin_pu, .gp_pin_value(), .wake_irq, .radio_txd, .radio_rxd,
    .rxd_sample());
  rhp_host_model hm (.clk, .txd(radio_txd), .hold, .rts_n, .rxd(radio_rxd), .rx_byte,
    .rx_stb);
  task chk(input [7:0] got_v, input [7:0] exp_v);
    compares = compares + 1;
    if (got_v !== exp_v) begin
      n_fail = n_fail + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask
  task tick(input integer c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task end_sim;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run is about 40000 cycles; the ceiling leaves room for slow bytes
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      end_sim;
    end
    if (rx_stb === 1'b1) begin
      got[n_got] = rx_byte;
      n_got = n_got + 1;
    end
  end
  initial begin
    {n_fail, compares, cyc, n_got} = 0;
    {pkt_tx_data, pkt_tx_ack_only, pkt_rx_valid, diag_alt_sel, diag_serial_tx} = 5'h00;
    {flow_alt_sel, sleep, cfg_load, host_tx_valid, hold, host_tx_data} = 13'h0000;
    {host_rx_ready, carrier_detect_n_in, gpi, reset_n} = 7'h7E;
    {gp_dir_awake, gp_pu_awake, gp_out_awake, gp_wake_en} = 20'h38000;
    {gp_dir_sleep, gp_pu_sleep, gp_out_sleep, gp_out_poweron} = 20'h00005;
    tick(4);
    chk({tx_activity, carrier_detect_n, radio_txd}, 8'h03);
    chk(gp_pin_pu, 8'h1F);
    reset_n = 1'b1;
    tick(3);
    chk(gp_pin_out[2:0], 8'h05);
    chk(diag_serial_rx, 8'h01);
    for (k = 0; k < 4; k = k + 1) begin
      {pkt_tx_data, pkt_tx_ack_only, pkt_rx_valid} = {k != 2, k == 1, k >= 2};
      tick(1);
      {pkt_tx_data, pkt_tx_ack_only, pkt_rx_valid} = 3'h0;
      tick(1);
      chk(tx_activity, k == 0 || k == 3);
      chk(carrier_detect_n, k < 2);
      tick(1010);
    end
    {gp_dir_sleep, gp_pu_sleep, gp_wake_en, sleep} = 16'h30C3;
    tick(4);
    chk({gp_pin_oe[2:0], gp_pin_pu[2:0]}, 8'h31);
    gpi[0] = 1'b0;
    n = 0;
    for (k = 0; k < 6; k = k + 1) begin
      tick(1);
      n = n | (wake_irq === 1'b1);
    end
    chk(n[7:0], 8'h01);
    {sleep, gpi[0]} = 2'h1;
    tick(4);
    chk(gp_pin_oe[2:0], 8'h07);
    {diag_alt_sel, flow_alt_sel, gp_out_awake, cfg_load} = 8'hC5;
    tick(1);
    {cfg_load, carrier_detect_n_in, diag_serial_tx, hold} = 4'h3;
    tick(4);
    chk(gp_pin_out[2:0], 8'h02);
    chk({carrier_detect_n_oe, diag_serial_rx, tx_activity}, 8'h01);
    // Held RTS keeps the transmitter off, so only the FIFO absorbs bytes
    n = 0;
    while (host_tx_ready === 1'b1 && n < 8) begin
      host_tx_data = 8'hA5 + n[7:0] * 8'h13;
      host_tx_valid = 1'b1;
      tick(1);
      host_tx_valid = 1'b0;
      tick(2);
      n = n + 1;
    end
    chk(n[7:0], `RHP_FIFO_DEPTH);
    chk({gp_pin_out[3], radio_txd}, 8'h03);
    hold = 1'b0;
    wait (n_got == `RHP_FIFO_DEPTH);
    for (k = 0; k < `RHP_FIFO_DEPTH; k = k + 1)
      chk(got[k], 8'hA5 + k[7:0] * 8'h13);
    tick(2);
    chk(gp_pin_out[3], 8'h00);
    end_sim;
  end
endmodule // testbench
